// ### rtl/uart_mode_map.svh
// register map, command codes and counts for the channel mode block
`ifndef UART_MODE_MAP_SVH
`define UART_MODE_MAP_SVH
`define OFS_MODE      2'h0
`define OFS_CMD       2'h1
`define OFS_STAT      2'h2
`define CHAN_BIT      4
`define CMD_PTR_MR1   4'h1
`define CMD_ERR_RST   4'h4
`define CMD_RTS_ON    4'h8
`define CMD_RTS_OFF   4'h9
`define CMD_PTR_MR0   4'hB
`define WDOG_BITS     7'h40
`define FIFO_DEPTH    4'h8
`define MR_RST        8'h00
`define CHB_MR0_MASK  8'hF0
`endif

// ### rtl/uart_mode_pkg.sv
// types shared by the channel mode block
package uart_mode_pkg;
    typedef enum logic [1:0] {CM_NORMAL = 2'h0, CM_ECHO = 2'h1, CM_LOCAL = 2'h2, CM_REMOTE = 2'h3} chan_mode_t;
    typedef enum logic [1:0] {PTR_MR0 = 2'h0, PTR_MR1 = 2'h1, PTR_MR2 = 2'h3} mr_ptr_t;
    typedef enum logic [1:0] {RTS_IDLE = 2'h0, RTS_SEND = 2'h1, RTS_WAIT = 2'h3} rts_state_t;
    typedef struct packed {
        logic [3:0] data_bits;
        logic       par_en;
        logic       par_force;
        logic       par_type;
        logic       multidrop;
        logic       err_block;
        logic [5:0] stop_16th;
        logic [1:0] baud_set;
    } fmt_t;
endpackage

// ### rtl/uart_mode_ctrl.sv
// mode registers, thresholds, flow control and line routing for two channels
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "uart_mode_map.svh"
// Overview of operation
// - pointer: reset/cmd to mr1, cmd B to mr0, mr1 access goes mr2, mr2 stays
// - watchdog bit: raise rx interrupt after 64 idle rx bit times
// - rx threshold from mr0[6],mr1[6]: 1, 3, 6 or 8 bytes
// - tx threshold: 8, 4, 6 or 1 empty positions
// - empty tx fifo requests after enable; one byte withdraws at level 00
// - rx flow: negate rts on start with full fifo, keep latch, reassert later
// - start of tenth byte with fifo still full flags overrun, drops byte
// - error mode bit picks character or block error reporting
// - with/forced parity appends and checks parity; code 11 is multidrop
// - parity type sets odd/even, forced value or address bit polarity
// - bits per character counts data bits only
// - echo mode resends rx data, tx status inactive, host tx path off
// - echo still checks parity and framing, echoes bits and breaks
// - local loop feeds tx into rx, output held high, input ignored
// - remote loop resends with one bit delay, no host data, no checks
// - mode change is immediate except finishing an echoed stop bit
// - tx rts control clears latch one bit time after all sent
// - cts control: send only while cts low, sampled per character
// - stop length in sixteenths, 5 bit characters start at 1-1/16
// - receiver checks only the stop bit centre for mark
// - external 1x tx clock: stop top bit picks one or two stops
// - channel B has the same fields on its own signals, except its mr0 bits 3:0 are masked to zero
module uart_mode_ctrl (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata_ff,
    output logic                     hreadyout_ff,
    output logic                     hresp_ff,
    input  wire logic [1:0][3:0]     rx_level,
    input  wire logic [1:0][3:0]     tx_level,
    input  wire logic [1:0]          rx_fifo_access,
    input  wire logic [1:0]          rx_start_bit,
    input  wire logic [1:0]          rx_stop_sampled,
    input  wire logic [1:0]          rx_bit_tick,
    input  wire logic [1:0]          tx_bit_tick,
    input  wire logic [1:0]          tx_all_sent,
    input  wire logic [1:0]          tx_enabled,
    input  wire logic [1:0]          tx_ext_1x,
    input  wire logic [1:0]          tx_serial_bit,
    input  wire logic [1:0]          serial_in_line,
    input  wire logic [1:0]          clear_to_send_in_n,
    output uart_mode_pkg::fmt_t [1:0] fmt_ff,
    output uart_mode_pkg::chan_mode_t [1:0] chan_mode_ff,
    output logic      [1:0]          rx_irq_ff,
    output logic      [1:0]          tx_irq_ff,
    output logic      [1:0]          request_to_send_out_n_ff,
    output logic      [1:0]          serial_out_line_ff,
    output logic      [1:0]          rx_line_ff,
    output logic      [1:0]          tx_permit_ff,
    output logic      [1:0]          rx_deliver_ff,
    output logic      [1:0]          tx_host_ff,
    output logic      [1:0]          overrun_ff,
    output logic      [1:0]          discard_ff
);
    logic [1:0][7:0]                 mr0_ff;
    logic [1:0][7:0]                 mr1_ff;
    logic [1:0][7:0]                 mr2_ff;
    uart_mode_pkg::mr_ptr_t [1:0]    ptr_ff;
    uart_mode_pkg::rts_state_t [1:0] rts_st_ff;
    logic                            wr_pend_ff;
    logic                            wr_ch_ff;
    logic [1:0]                      wr_reg_ff;
    logic [1:0][6:0]                 wd_cnt_ff;
    logic [1:0]                      wdog_ff;
    logic [1:0]                      hold_ff;
    logic [1:0]                      ninth_ff;
    logic [1:0]                      latch_ff;
    logic [1:0]                      rx_s1_ff;
    logic [1:0]                      rx_s2_ff;
    logic [1:0]                      cts_s1_ff;
    logic [1:0]                      cts_s2_ff;
    logic [1:0]                      echo_ff;
    logic [1:0]                      stop_seen_ff;
    logic [1:0]                      keep_mode_ff;
    logic                            acc;
    logic                            rd_ch;
    logic [1:0]                      rd_reg;
    logic [1:0]                      cmd_wr;
    logic [1:0]                      rd_mode;
    logic [1:0]                      wr_mode;

    function automatic logic [3:0] rx_need(input logic [1:0] code);
        case (code)
            2'h0:    rx_need = 4'h1;
            2'h1:    rx_need = 4'h3;
            2'h2:    rx_need = 4'h6;
            default: rx_need = `FIFO_DEPTH;
        endcase
    endfunction

    function automatic logic [3:0] tx_need(input logic [1:0] code);
        case (code)
            2'h0:    tx_need = `FIFO_DEPTH;
            2'h1:    tx_need = 4'h4;
            2'h2:    tx_need = 4'h6;
            default: tx_need = 4'h1;
        endcase
    endfunction

    function automatic uart_mode_pkg::mr_ptr_t ptr_step(input uart_mode_pkg::mr_ptr_t p);
        ptr_step = (p == uart_mode_pkg::PTR_MR0) ? uart_mode_pkg::PTR_MR1 : uart_mode_pkg::PTR_MR2;
    endfunction

    function automatic uart_mode_pkg::fmt_t decode(input logic [7:0] m0, input logic [7:0] m1,
                                                    input logic [7:0] m2, input logic ext);
        uart_mode_pkg::fmt_t f;
        f = '0;
        f.data_bits = 4'h5 + {2'h0, m1[1:0]};
        f.par_en    = (m1[4:3] == 2'h0) | (m1[4:3] == 2'h1);
        f.par_force = (m1[4:3] == 2'h1);
        f.multidrop = (m1[4:3] == 2'h3);
        f.par_type  = m1[2];
        f.err_block = m1[5];
        f.baud_set  = {m0[2], m0[0]};
        if (ext) begin
            f.stop_16th = m2[3] ? 6'h20 : 6'h10;
        end else if (m1[1:0] == 2'h0) begin
            f.stop_16th = 6'h11 + {2'h0, m2[3:0]};
        end else begin
            f.stop_16th = 6'h09 + {2'h0, m2[3:0]} + (m2[3] ? 6'h08 : 6'h00);
        end
        decode = f;
    endfunction

    assign acc     = hsel & hready & htrans[1];
    assign rd_ch   = haddr[`CHAN_BIT];
    assign rd_reg  = haddr[3:2];
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            cmd_wr[c]  = wr_pend_ff & (wr_ch_ff == c[0]) & (wr_reg_ff == `OFS_CMD);
            wr_mode[c] = wr_pend_ff & (wr_ch_ff == c[0]) & (wr_reg_ff == `OFS_MODE);
            rd_mode[c] = acc & ~hwrite & (rd_ch == c[0]) & (rd_reg == `OFS_MODE);
        end
    end

    // bus slave: zero wait states, read data registered in address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff   <= 1'b0;
            wr_ch_ff     <= 1'b0;
            wr_reg_ff    <= 2'h0;
            hrdata_ff    <= 32'h0000_0000;
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
        end else begin
            wr_pend_ff <= acc & hwrite;
            wr_ch_ff   <= rd_ch;
            wr_reg_ff  <= rd_reg;
            hrdata_ff  <= 32'h0000_0000;
            if (acc & ~hwrite & (rd_reg == `OFS_MODE)) begin
                case (ptr_ff[rd_ch])
                    uart_mode_pkg::PTR_MR0: hrdata_ff[7:0] <= mr0_ff[rd_ch];
                    uart_mode_pkg::PTR_MR1: hrdata_ff[7:0] <= mr1_ff[rd_ch];
                    default:                hrdata_ff[7:0] <= mr2_ff[rd_ch];
                endcase
            end else if (acc & ~hwrite & (rd_reg == `OFS_STAT)) begin
                hrdata_ff[9:0] <= {ptr_ff[rd_ch], latch_ff[rd_ch], hold_ff[rd_ch], overrun_ff[rd_ch],
                                   wdog_ff[rd_ch], tx_irq_ff[rd_ch], rx_irq_ff[rd_ch], chan_mode_ff[rd_ch]};
            end
        end
    end

    // pointer and mode register storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int c = 0; c < 2; c++) begin
                ptr_ff[c] <= uart_mode_pkg::PTR_MR1;
                mr0_ff[c] <= `MR_RST;
                mr1_ff[c] <= `MR_RST;
                mr2_ff[c] <= `MR_RST;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (cmd_wr[c] & (hwdata[7:4] == `CMD_PTR_MR1)) begin
                    ptr_ff[c] <= uart_mode_pkg::PTR_MR1;
                end else if (cmd_wr[c] & (hwdata[7:4] == `CMD_PTR_MR0)) begin
                    ptr_ff[c] <= uart_mode_pkg::PTR_MR0;
                end else if (rd_mode[c] | wr_mode[c]) begin
                    ptr_ff[c] <= ptr_step(ptr_ff[c]);
                end
                if (wr_mode[c]) begin
                    case (ptr_ff[c])
                        uart_mode_pkg::PTR_MR0: mr0_ff[c] <= (c == 1) ? (hwdata[7:0] & `CHB_MR0_MASK)
                                                                      : hwdata[7:0];
                        uart_mode_pkg::PTR_MR1: mr1_ff[c] <= hwdata[7:0];
                        default:                mr2_ff[c] <= hwdata[7:0];
                    endcase
                end
            end
        end
    end

    // format decode and pin synchronisers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fmt_ff    <= '0;
            rx_s1_ff  <= 2'h3;
            rx_s2_ff  <= 2'h3;
            cts_s1_ff <= 2'h3;
            cts_s2_ff <= 2'h3;
        end else begin
            for (int c = 0; c < 2; c++) begin
                fmt_ff[c] <= decode(mr0_ff[c], mr1_ff[c], mr2_ff[c], tx_ext_1x[c]);
            end
            rx_s1_ff  <= serial_in_line;
            rx_s2_ff  <= rx_s1_ff;
            cts_s1_ff <= clear_to_send_in_n;
            cts_s2_ff <= cts_s1_ff;
        end
    end

    // receive watchdog
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wd_cnt_ff <= '0;
            wdog_ff   <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (~mr0_ff[c][7] | (rx_level[c] == 4'h0)) begin
                    wd_cnt_ff[c] <= 7'h00;
                    wdog_ff[c]   <= 1'b0;
                end else if (rx_bit_tick[c] & (wd_cnt_ff[c] == `WDOG_BITS - 7'h01)) begin
                    wd_cnt_ff[c] <= `WDOG_BITS;
                    wdog_ff[c]   <= 1'b1;
                end else if (rx_fifo_access[c]) begin
                    wd_cnt_ff[c] <= 7'h00;
                    wdog_ff[c]   <= 1'b0;
                end else if (rx_bit_tick[c] & (wd_cnt_ff[c] < `WDOG_BITS)) begin
                    wd_cnt_ff[c] <= wd_cnt_ff[c] + 7'h01;
                end
            end
        end
    end

    // interrupt requests from fill levels
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_irq_ff <= 2'h0;
            tx_irq_ff <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                rx_irq_ff[c] <= (chan_mode_ff[c] != uart_mode_pkg::CM_REMOTE) & (wdog_ff[c] |
                                (rx_level[c] >= rx_need({mr0_ff[c][6], mr1_ff[c][6]})));
                tx_irq_ff[c] <= (chan_mode_ff[c] != uart_mode_pkg::CM_ECHO) & tx_enabled[c] &
                                ((`FIFO_DEPTH - tx_level[c]) >= tx_need(mr0_ff[c][5:4]));
            end
        end
    end

    // receive flow control and overrun
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_ff    <= 2'h0;
            ninth_ff   <= 2'h0;
            overrun_ff <= 2'h0;
            discard_ff <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                discard_ff[c] <= rx_start_bit[c] & (rx_level[c] == `FIFO_DEPTH) & ninth_ff[c];
                if (rx_start_bit[c] & (rx_level[c] == `FIFO_DEPTH)) begin
                    hold_ff[c]  <= mr1_ff[c][7];
                    ninth_ff[c] <= 1'b1;
                end else if (rx_level[c] < `FIFO_DEPTH) begin
                    hold_ff[c]  <= 1'b0;
                    ninth_ff[c] <= 1'b0;
                end
                if (rx_start_bit[c] & (rx_level[c] == `FIFO_DEPTH) & ninth_ff[c]) begin
                    overrun_ff[c] <= 1'b1;
                end else if (cmd_wr[c] & (hwdata[7:4] == `CMD_ERR_RST)) begin
                    overrun_ff[c] <= 1'b0;
                end
            end
        end
    end

    // output latch bit and transmitter auto clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_ff  <= 2'h0;
            for (int c = 0; c < 2; c++) begin
                rts_st_ff[c] <= uart_mode_pkg::RTS_IDLE;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                case (rts_st_ff[c])
                    uart_mode_pkg::RTS_IDLE: if (mr2_ff[c][5] & ~tx_all_sent[c]) begin
                        rts_st_ff[c] <= uart_mode_pkg::RTS_SEND;
                    end
                    uart_mode_pkg::RTS_SEND: if (~mr2_ff[c][5]) begin
                        rts_st_ff[c] <= uart_mode_pkg::RTS_IDLE;
                    end else if (tx_all_sent[c]) begin
                        rts_st_ff[c] <= uart_mode_pkg::RTS_WAIT;
                    end
                    uart_mode_pkg::RTS_WAIT: if (~mr2_ff[c][5] | tx_bit_tick[c]) begin
                        rts_st_ff[c] <= uart_mode_pkg::RTS_IDLE;
                    end
                    default: rts_st_ff[c] <= uart_mode_pkg::RTS_IDLE;
                endcase
                if (cmd_wr[c] & (hwdata[7:4] == `CMD_RTS_ON)) begin
                    latch_ff[c] <= 1'b1;
                end else if ((cmd_wr[c] & (hwdata[7:4] == `CMD_RTS_OFF)) |
                             ((rts_st_ff[c] == uart_mode_pkg::RTS_WAIT) & mr2_ff[c][5] & tx_bit_tick[c])) begin
                    latch_ff[c] <= 1'b0;
                end
            end
        end
    end

    // flow pins and clear-to-send gate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            request_to_send_out_n_ff <= 2'h3;
            tx_permit_ff             <= 2'h3;
        end else begin
            for (int c = 0; c < 2; c++) begin
                request_to_send_out_n_ff[c] <= ~(latch_ff[c] & ~hold_ff[c]);
                tx_permit_ff[c] <= ~mr2_ff[c][4] | ~cts_s2_ff[c];
            end
        end
    end

    // channel mode with echoed stop bit completion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int c = 0; c < 2; c++) begin
                chan_mode_ff[c] <= uart_mode_pkg::CM_NORMAL;
            end
            stop_seen_ff <= 2'h0;
            keep_mode_ff <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (rx_stop_sampled[c]) begin
                    stop_seen_ff[c] <= 1'b1;
                end else if (rx_bit_tick[c]) begin
                    stop_seen_ff[c] <= 1'b0;
                end
                if (keep_mode_ff[c]) begin
                    keep_mode_ff[c] <= ~rx_bit_tick[c];
                end else if ((chan_mode_ff[c] == uart_mode_pkg::CM_ECHO |
                              chan_mode_ff[c] == uart_mode_pkg::CM_REMOTE) &
                             (mr2_ff[c][7:6] != chan_mode_ff[c]) & stop_seen_ff[c] & tx_enabled[c]) begin
                    keep_mode_ff[c] <= 1'b1;
                end else begin
                    chan_mode_ff[c] <= uart_mode_pkg::chan_mode_t'(mr2_ff[c][7:6]);
                end
            end
        end
    end

    // serial line routing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            echo_ff            <= 2'h3;
            serial_out_line_ff <= 2'h3;
            rx_line_ff         <= 2'h3;
            rx_deliver_ff      <= 2'h3;
            tx_host_ff         <= 2'h3;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (rx_bit_tick[c]) begin
                    echo_ff[c] <= rx_s2_ff[c];
                end
                case (chan_mode_ff[c])
                    uart_mode_pkg::CM_ECHO,
                    uart_mode_pkg::CM_REMOTE: serial_out_line_ff[c] <= echo_ff[c];
                    uart_mode_pkg::CM_LOCAL:  serial_out_line_ff[c] <= 1'b1;
                    default:                  serial_out_line_ff[c] <= tx_serial_bit[c];
                endcase
                rx_line_ff[c] <= (chan_mode_ff[c] == uart_mode_pkg::CM_LOCAL) ? tx_serial_bit[c]
                                                                             : rx_s2_ff[c];
                rx_deliver_ff[c] <= (chan_mode_ff[c] != uart_mode_pkg::CM_REMOTE);
                tx_host_ff[c]    <= (chan_mode_ff[c] != uart_mode_pkg::CM_ECHO);
            end
        end
    end

    AST_PTR_ADV: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_mode[0] & ~cmd_wr[0] & (ptr_ff[0] == uart_mode_pkg::PTR_MR1) |=> ptr_ff[0] == uart_mode_pkg::PTR_MR2)
        else $error("pointer did not advance to mr2");
    AST_WDOG: assert property (@(posedge hclk) disable iff (!hresetn)
        wdog_ff[0] & (chan_mode_ff[0] != uart_mode_pkg::CM_REMOTE) |=> rx_irq_ff[0])
        else $error("watchdog did not raise rx interrupt");
    AST_RX_LVL: assert property (@(posedge hclk) disable iff (!hresetn)
        (mr0_ff[0][6] & mr1_ff[0][6] & $stable(mr0_ff[0]) & (rx_level[0] == 4'h7) & ~wdog_ff[0])
        |=> ~rx_irq_ff[0])
        else $error("rx interrupt below eight bytes");
    AST_TX_LVL: assert property (@(posedge hclk) disable iff (!hresetn)
        (mr0_ff[0][5:4] == 2'h1) & tx_enabled[0] & (tx_level[0] == 4'h5) & (chan_mode_ff[0] == 2'h0)
        |=> ~tx_irq_ff[0])
        else $error("tx interrupt with three empty");
    AST_RTS_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_start_bit[0] & (rx_level[0] == 4'h8) & mr1_ff[0][7] |=> ##1 request_to_send_out_n_ff[0])
        else $error("rts not negated on full fifo");
    AST_OVERRUN: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_start_bit[0] & (rx_level[0] == 4'h8) & ninth_ff[0] |=> overrun_ff[0] & discard_ff[0])
        else $error("tenth byte not flagged");
    AST_ECHO_TX: assert property (@(posedge hclk) disable iff (!hresetn)
        chan_mode_ff[0] == uart_mode_pkg::CM_ECHO |=> ~tx_irq_ff[0] & ~tx_host_ff[0])
        else $error("tx status active in echo");
    AST_LOCAL_HIGH: assert property (@(posedge hclk) disable iff (!hresetn)
        chan_mode_ff[0] == uart_mode_pkg::CM_LOCAL |=> serial_out_line_ff[0])
        else $error("output not high in local loop");
    AST_RTS_AUTO: assert property (@(posedge hclk) disable iff (!hresetn)
        (rts_st_ff[0] == uart_mode_pkg::RTS_WAIT) & mr2_ff[0][5] & tx_bit_tick[0] & ~cmd_wr[0]
        |=> ~latch_ff[0] ##1 request_to_send_out_n_ff[0])
        else $error("latch not cleared after send");
    AST_CTS: assert property (@(posedge hclk) disable iff (!hresetn)
        mr2_ff[0][4] & $stable(mr2_ff[0]) & cts_s2_ff[0] |=> ~tx_permit_ff[0])
        else $error("transmit permitted with cts high");
    COV_ECHO: cover property (@(posedge hclk) disable iff (!hresetn) chan_mode_ff[0] == uart_mode_pkg::CM_ECHO);
    COV_WDOG: cover property (@(posedge hclk) disable iff (!hresetn) $rose(wdog_ff[0]));
    COV_OVR:  cover property (@(posedge hclk) disable iff (!hresetn) $rose(overrun_ff[0]));
    COV_KEEP: cover property (@(posedge hclk) disable iff (!hresetn) $rose(keep_mode_ff[0]));
endmodule

// ### verif/uart_line_partner.sv
// remote serial partner: bit clocks and a toggling line
`timescale 1ns/1ps
module uart_line_partner (
    input  wire logic       hclk,
    output logic      [1:0] serial_in_line,
    output logic      [1:0] rx_bit_tick,
    output logic      [1:0] tx_bit_tick
);
    logic [3:0] div;
    initial begin
        div = 4'h0;
        serial_in_line = 2'h3;
        rx_bit_tick = 2'h0;
        tx_bit_tick = 2'h0;
    end
    always @(posedge hclk) begin
        div <= div + 4'h1;
        rx_bit_tick <= {2{div == 4'hF}};
        tx_bit_tick <= {2{div == 4'h7}};
        if (div == 4'hF) serial_in_line <= ~serial_in_line;
    end
endmodule

// ### verif/uart_mode_ctrl_tb_top.sv
// register and flow tests for the channel mode block
`timescale 1ns/1ps
`include "uart_mode_map.svh"
module uart_mode_ctrl_tb_top;
    localparam logic [31:0] MD = 32'h0, CM = 32'h4, ST = 32'h8;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0, start = 2'h0, sent = 2'h3, tx_en = 2'h0, rxa = 2'h0, cts = 2'h0;
    logic [1:0] sin, rt, tt, sout, rxi, txi, rts_n, ovr, host, dlv, perm;
    logic [1:0][3:0] rxl = '0, txl = '0;
    uart_mode_pkg::fmt_t [1:0] fmt;
    uart_mode_pkg::chan_mode_t [1:0] mode;
    int err_count = 0, samples_checked = 0, rxt[4] = '{1, 3, 6, 8}, txe[4] = '{8, 4, 6, 1};
    always #20 hclk = ~hclk;
    uart_line_partner uart_line_partner_i (.hclk, .serial_in_line(sin), .rx_bit_tick(rt), .tx_bit_tick(tt));
    uart_mode_ctrl uart_mode_ctrl_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready, .hrdata_ff(hrdata), .hreadyout_ff(hready), .hresp_ff(), .rx_level(rxl),
        .tx_level(txl), .rx_fifo_access(rxa), .rx_start_bit(start), .rx_stop_sampled(2'h0),
        .rx_bit_tick(rt), .tx_bit_tick(tt), .tx_all_sent(sent), .tx_enabled(tx_en), .tx_ext_1x(2'h0),
        .tx_serial_bit(2'h3), .serial_in_line(sin), .clear_to_send_in_n(cts), .fmt_ff(fmt),
        .chan_mode_ff(mode), .rx_irq_ff(rxi), .tx_irq_ff(txi), .request_to_send_out_n_ff(rts_n),
        .serial_out_line_ff(sout), .rx_line_ff(), .tx_permit_ff(perm), .rx_deliver_ff(dlv),
        .tx_host_ff(host), .overrun_ff(ovr), .discard_ff());
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        wrap_up();
    end
    initial begin
        wt(6); hresetn <= 1'b1; wt(1);
        bus(0, ST, 0); chk("ptr", rd[9:8], 2'h1);
        bus(0, MD, 0); chk("mr1", rd, 0);
        bus(0, ST, 0); chk("ptr", rd[9:8], 2'h3);
        bus(1, 32'hC, 32'hFF); bus(0, 32'hC, 0); chk("unmapped", rd, 0);
        bus(1, CM, {`CMD_PTR_MR0, 4'h0}); bus(0, MD, 0); chk("mr0", rd, 0);
        $display("reset test done");
        tx_en <= 2'h1;
        for (int i = 0; i < 4; i++) begin
            bus(1, CM, {`CMD_PTR_MR0, 4'h0}); bus(1, MD, {1'b0, i[1], i[1:0], 4'h0});
            bus(1, MD, {1'b0, i[0], 6'h0});
            for (int k = 0; k < 2; k++) begin
                rxl[0] <= 4'(rxt[i] - 1 + k); txl[0] <= 4'(9 - txe[i] - k); wt(3);
                chk("rx irq", rxi[0], k);
                chk("tx irq", txi[0], k);
            end
        end
        bus(1, CM, {`CMD_PTR_MR0, 4'h0}); bus(1, MD, 8'hF0); bus(1, MD, 8'h40); rxl[0] <= 4'h1;
        wt(900); chk("wdog early", rxi[0], 0); wt(200); chk("wdog", rxi[0], 1);
        rxa <= 2'h1; wt(1); rxa <= 2'h0; wt(3); chk("wdog clear", rxi[0], 0);
        rxl[0] <= 4'h0;
        $display("threshold test done");
        for (int m = 0; m < 4; m++) begin
            bus(1, MD, {m[1:0], 6'h0}); wt(3);
            chk("mode", mode[0], m[1:0]);
            chk("host tx", host[0], m != 1);
            chk("deliver", dlv[0], m != 3);
            if (m == 1) chk("echo tx irq", txi[0], 0);
            if (m == 2) chk("loop line", sout[0], 1);
        end
        bus(1, MD, 8'h20); bus(1, CM, {`CMD_RTS_ON, 4'h0}); wt(3); chk("rts", rts_n[0], 0);
        sent <= 2'h2; wt(3); sent <= 2'h3; wt(40); chk("rts auto", rts_n[0], 1);
        $display("mode test done");
        cts <= 2'h1; bus(1, CM, {`CMD_PTR_MR1, 4'h0}); bus(1, MD, 8'hA7); bus(1, MD, 8'h10); wt(2);
        chk("fmt", {fmt[0].data_bits, fmt[0].par_en, fmt[0].par_force, fmt[0].par_type,
            fmt[0].multidrop, fmt[0].err_block, fmt[0].stop_16th}, {4'h8, 5'b10101, 6'h09});
        chk("cts stop", perm[0], 0); cts <= 2'h0; wt(4); chk("cts go", perm[0], 1);
        bus(1, CM, {`CMD_RTS_ON, 4'h0}); rxl[0] <= 4'h8;
        wt(1); start <= 2'h1; wt(1); start <= 2'h0; wt(4);
        chk("rts full", rts_n[0], 1);
        chk("no ovr", ovr[0], 0);
        start <= 2'h1; wt(1); start <= 2'h0; wt(3); chk("ovr", ovr[0], 1);
        rxl[0] <= 4'h7; wt(4); chk("rts back", rts_n[0], 0);
        bus(0, ST, 0); chk("latch", rd[7], 1);
        $display("flow test done");
        wrap_up();
    end
endmodule
